// ---- hw/afc_pkg.sv ----
// constants for the automatic flow control trigger of the host mac
// assumes a 200 mhz register clock shared with the mac receive logic
package afc_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0]  CFG_OFFSET    = 8'hac;
  localparam logic [7:0]  STATUS_OFFSET = 8'hc0;
  localparam logic [31:0] CFG_RESET     = 32'h0000_0000;
  localparam logic [31:0] CFG_WMASK     = 32'h00ff_ffff;

  // ==========================================================
  // config fields
  localparam int HI_MSB    = 23;
  localparam int HI_LSB    = 16;
  localparam int LO_MSB    = 15;
  localparam int LO_LSB    = 8;
  localparam int DUR_MSB   = 7;
  localparam int DUR_LSB   = 4;
  localparam int MULT_BIT  = 3;
  localparam int BRD_BIT   = 2;
  localparam int ADDR_BIT  = 1;
  localparam int ANY_BIT   = 0;
  localparam int UNIT_SHIFT = 6; // thresholds count 64-byte units

  // status fields
  localparam int ST_HI_SEEN_BIT = 0;
  localparam int ST_SENT_BIT    = 1;
  localparam int ST_WINDOW_BIT  = 2;
  localparam int ST_JAM_BIT     = 3;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS   = 5;
  localparam int US_NS           = 1000;
  localparam int BP_US_0         = 5;
  localparam int BP_US_1         = 10;
  localparam int BP_US_2         = 15;
  localparam int BP_US_3         = 25;
  localparam int BP_STEP_US      = 50;
  localparam int BP_STEP_BASE    = 3;
  localparam int BP_10M_EXTRA_NS = 2200;
  localparam int US_CYCLES       = US_NS / CLK_PERIOD_NS;
  localparam int EXTRA_10M_CYCLES = BP_10M_EXTRA_NS / CLK_PERIOD_NS;

endpackage : afc_pkg

// ---- hw/auto_flow_control_trigger.sv ----
// automatic flow control trigger: pause requests and half-duplex jamming
// assumes mac inputs on pclk, apb slave on pclk, pclken high for bus use
//
// Contract
// - trigger at fifo bytes >= high field times 64
// - full duplex: one non-zero pause per reach
// - half duplex: jam qualifying frames for duration
// - below low level: send zero-time pause
// - zero pause only after sent pause, enabled
// - duration field used only for backpressure
// - multicast qualifier in half duplex only
// - broadcast qualifier in half duplex only
// - station address qualifier in half duplex
// - any-frame bit; sole full duplex enable
// - any-frame half duplex jams at preamble
// - any-frame full duplex requests pause at once
// - any-frame overrides the three qualifiers
// - duration table, plus 2.2 us at 10M
// - duration timed from high-level reach
// - nothing sent while transmitter disabled
`timescale 1ns/1ps
`default_nettype none

module auto_flow_control_trigger #(
  parameter int FIFO_CNT_W       = 16,
  parameter int US_CYCLES        = afc_pkg::US_CYCLES,
  parameter int EXTRA_10M_CYCLES = afc_pkg::EXTRA_10M_CYCLES
) (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  pclken,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // mac mode
  input  wire logic                  full_duplex,
  input  wire logic                  speed_100,
  input  wire logic                  tx_enable,
  // receive side
  input  wire logic [FIFO_CNT_W-1:0] rx_fifo_bytes,
  input  wire logic                  rx_preamble,
  input  wire logic                  rx_da_valid,
  input  wire logic                  rx_is_multicast,
  input  wire logic                  rx_is_broadcast,
  input  wire logic                  rx_addr_match,
  // transmit side
  output logic                       pause_req,
  output logic                       pause_zero,
  output logic                       jam
);

  // ==========================================================
  // state
  logic [31:0] auto_flow_control_config;
  logic        hi_seen;
  logic        pause_sent;
  logic        bp_window;
  logic [31:0] bp_count;

  logic [7:0] fifo_high_threshold;
  logic [7:0] fifo_low_threshold;
  logic [3:0] backpressure_duration_sel;
  logic       qualify_on_multicast;
  logic       qualify_on_broadcast;
  logic       qualify_on_station_address;
  logic       qualify_on_any_frame;

  assign fifo_high_threshold =
    auto_flow_control_config[afc_pkg::HI_MSB:afc_pkg::HI_LSB];
  assign fifo_low_threshold =
    auto_flow_control_config[afc_pkg::LO_MSB:afc_pkg::LO_LSB];
  assign backpressure_duration_sel =
    auto_flow_control_config[afc_pkg::DUR_MSB:afc_pkg::DUR_LSB];
  assign qualify_on_multicast       = auto_flow_control_config[afc_pkg::MULT_BIT];
  assign qualify_on_broadcast       = auto_flow_control_config[afc_pkg::BRD_BIT];
  assign qualify_on_station_address = auto_flow_control_config[afc_pkg::ADDR_BIT];
  assign qualify_on_any_frame       = auto_flow_control_config[afc_pkg::ANY_BIT];

  // ==========================================================
  // helpers
  function automatic logic [FIFO_CNT_W+7:0] level_bytes(input logic [7:0] units);
    level_bytes = {{(FIFO_CNT_W - 6){1'b0}}, units, 6'h00};
  endfunction : level_bytes

  function automatic logic [31:0] dur_cycles(input logic [3:0] sel, input logic slow);
    logic [31:0] us;
    us = 32'h0000_0000;
    unique case (sel)
      4'h0:    us = 32'(afc_pkg::BP_US_0);
      4'h1:    us = 32'(afc_pkg::BP_US_1);
      4'h2:    us = 32'(afc_pkg::BP_US_2);
      4'h3:    us = 32'(afc_pkg::BP_US_3);
      default: us = 32'(afc_pkg::BP_STEP_US) * (32'(sel) - 32'(afc_pkg::BP_STEP_BASE));
    endcase
    dur_cycles = 32'(us * 32'(US_CYCLES)) + (slow ? 32'(EXTRA_10M_CYCLES) : 32'h0);
  endfunction : dur_cycles

  // ==========================================================
  // level compare, every cycle
  logic [FIFO_CNT_W+7:0] fifo_ext;
  logic at_hi;
  logic below_lo;
  logic hi_rise;
  logic fd_enabled;
  logic hd_enabled;
  logic frame_qualifies;

  assign fifo_ext  = {8'h00, rx_fifo_bytes};
  assign at_hi     = fifo_ext >= level_bytes(fifo_high_threshold);
  assign below_lo  = fifo_ext < level_bytes(fifo_low_threshold);
  assign hi_rise   = at_hi && !hi_seen;
  // any-frame is the only full duplex enable
  assign fd_enabled = full_duplex && qualify_on_any_frame && tx_enable;
  assign hd_enabled = !full_duplex && tx_enable && (auto_flow_control_config[3:0] != 4'h0);

  // any-frame jams on the preamble with no address decode
  always_comb begin
    if (qualify_on_any_frame) begin
      frame_qualifies = rx_preamble;
    end else begin
      frame_qualifies = rx_da_valid &&
        ((qualify_on_multicast && rx_is_multicast) ||
         (qualify_on_broadcast && rx_is_broadcast) ||
         (qualify_on_station_address && rx_addr_match));
    end
  end

  // ==========================================================
  // apb slave: answer prepared in setup, pready in access
  logic sel_cfg;
  logic sel_status;
  logic setup;
  logic access_done;

  assign sel_cfg     = paddr == afc_pkg::CFG_OFFSET;
  assign sel_status  = paddr == afc_pkg::STATUS_OFFSET;
  assign setup       = psel && !penable;
  assign access_done = psel && penable && pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (pclken) begin
      pready <= setup;
      if (setup) begin
        pslverr <= !(sel_cfg || sel_status);
        if (pwrite || !(sel_cfg || sel_status)) begin
          prdata <= 32'h0000_0000;
        end else if (sel_cfg) begin
          prdata <= auto_flow_control_config;
        end else begin
          prdata <= {28'h0000000, jam, bp_window, pause_sent, hi_seen};
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_flow_control_config <= afc_pkg::CFG_RESET;
    end else if (pclken && access_done && pwrite && sel_cfg) begin
      auto_flow_control_config <= pwdata & afc_pkg::CFG_WMASK;
    end
  end

  // ==========================================================
  // high-level tracking, rearmed once below the low level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_seen <= 1'b0;
    end else if (pclken) begin
      if (at_hi) begin
        hi_seen <= 1'b1;
      end else if (below_lo) begin
        hi_seen <= 1'b0;
      end
    end
  end

  // ==========================================================
  // full duplex pause requests; transmitter queues the pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_req  <= 1'b0;
      pause_zero <= 1'b0;
      pause_sent <= 1'b0;
    end else if (pclken) begin
      pause_req <= 1'b0;
      if (fd_enabled && hi_rise) begin
        pause_req  <= 1'b1;
        pause_zero <= 1'b0;
        pause_sent <= 1'b1;
      end else if (fd_enabled && pause_sent && below_lo) begin
        pause_req  <= 1'b1;
        pause_zero <= 1'b1;
        pause_sent <= 1'b0;
      end else if (!qualify_on_any_frame || !full_duplex) begin
        pause_sent <= 1'b0; // flow control off: nothing to resume
      end
    end
  end

  // ==========================================================
  // half duplex window, timed from the reach not the jam
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bp_window <= 1'b0;
      bp_count  <= 32'h0000_0000;
    end else if (pclken) begin
      if (hd_enabled && hi_rise) begin
        bp_window <= 1'b1;
        bp_count  <= dur_cycles(backpressure_duration_sel, !speed_100);
      end else if (!hd_enabled) begin
        bp_window <= 1'b0;
        bp_count  <= 32'h0000_0000;
      end else if (bp_window) begin
        if (bp_count <= 32'h0000_0001) begin
          bp_window <= 1'b0;
          bp_count  <= 32'h0000_0000;
        end else begin
          bp_count <= bp_count - 32'h0000_0001;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jam <= 1'b0;
    end else if (pclken) begin
      if (!hd_enabled || !bp_window) begin
        jam <= 1'b0;
      end else if (frame_qualifies) begin
        jam <= 1'b1;
      end
    end
  end

  // ==========================================================
  // checks
  property p_hi_pause;
    @(posedge pclk) disable iff (!presetn)
      pause_req && !pause_zero |-> $past(at_hi && !hi_seen && full_duplex);
  endproperty
  a_hi_pause: assert property (p_hi_pause)
    else $error("non-zero pause without high level reach");
  property p_zero_pause;
    @(posedge pclk) disable iff (!presetn)
      pause_req && pause_zero |-> $past(pause_sent) && $past(below_lo);
  endproperty
  a_zero_pause: assert property (p_zero_pause)
    else $error("zero pause without earlier pause");
  property p_tx_off;
    @(posedge pclk) disable iff (!presetn)
      pclken && !tx_enable |=> !pause_req;
  endproperty
  a_tx_off: assert property (p_tx_off)
    else $error("pause with transmitter disabled");
  property p_fd_no_jam;
    @(posedge pclk) disable iff (!presetn)
      pclken && full_duplex |=> !jam;
  endproperty
  a_fd_no_jam: assert property (p_fd_no_jam)
    else $error("jam in full duplex");
  property p_window_load;
    @(posedge pclk) disable iff (!presetn)
      pclken && hd_enabled && hi_rise |=>
        bp_window && bp_count == dur_cycles($past(backpressure_duration_sel), !$past(speed_100));
  endproperty
  a_window_load: assert property (p_window_load)
    else $error("backpressure window not loaded on reach");
  property p_mult_jam;
    @(posedge pclk) disable iff (!presetn)
      pclken && hd_enabled && bp_window && !qualify_on_any_frame && qualify_on_multicast
        && rx_da_valid && rx_is_multicast |=> jam;
  endproperty
  a_mult_jam: assert property (p_mult_jam)
    else $error("multicast frame not jammed");
  property p_any_jam;
    @(posedge pclk) disable iff (!presetn)
      pclken && hd_enabled && bp_window && qualify_on_any_frame && rx_preamble |=> jam;
  endproperty
  a_any_jam: assert property (p_any_jam)
    else $error("preamble not jammed in any-frame mode");
  property p_any_override;
    @(posedge pclk) disable iff (!presetn)
      pclken && !jam && qualify_on_any_frame && !rx_preamble |=> !jam;
  endproperty
  a_any_override: assert property (p_any_override)
    else $error("qualifier bit acted under any-frame");
  property p_fd_pause_now;
    @(posedge pclk) disable iff (!presetn)
      pclken && fd_enabled && hi_rise |=> pause_req && !pause_zero;
  endproperty
  a_fd_pause_now: assert property (p_fd_pause_now)
    else $error("pause not requested at once");
  // a zero pause may follow at once if the level collapses
  property p_one_pause;
    @(posedge pclk) disable iff (!presetn)
      pause_req && !pause_zero |=> !(pause_req && !pause_zero);
  endproperty
  a_one_pause: assert property (p_one_pause)
    else $error("more than one pause per reach");
  property p_jam_in_window;
    @(posedge pclk) disable iff (!presetn)
      pclken && !bp_window |=> !jam;
  endproperty
  a_jam_in_window: assert property (p_jam_in_window)
    else $error("jam outside backpressure window");
  property p_pause_enabled;
    @(posedge pclk) disable iff (!presetn)
      pause_req |-> $past(full_duplex && qualify_on_any_frame && tx_enable);
  endproperty
  a_pause_enabled: assert property (p_pause_enabled)
    else $error("pause without full duplex any-frame enable");
  property p_rearm_hold;
    @(posedge pclk) disable iff (!presetn)
      pclken && hi_seen && !below_lo |=> hi_seen;
  endproperty
  a_rearm_hold: assert property (p_rearm_hold)
    else $error("high level rearmed above the low level");
  property p_window_end;
    @(posedge pclk) disable iff (!presetn)
      pclken && bp_window && !hi_rise && bp_count <= 32'h0000_0001 |=> !bp_window;
  endproperty
  a_window_end: assert property (p_window_end)
    else $error("backpressure window overran its duration");

  c_fd_pause: cover property (@(posedge pclk) pause_req && !pause_zero);
  c_fd_resume: cover property (@(posedge pclk) pause_req && pause_zero);
  c_hd_jam: cover property (@(posedge pclk) $rose(jam));
  c_window_end: cover property (@(posedge pclk) $fell(bp_window));
  c_slow_window: cover property (@(posedge pclk) bp_window && !speed_100);

endmodule : auto_flow_control_trigger

`default_nettype wire

// ---- verif/rx_station_model.sv ----
// remote station model: frame start and address decode pulses
// assumes send_frame is called right after a rising pclk edge
`timescale 1ns/1ps
`default_nettype none
module rx_station_model (
  // clock
  input  wire logic pclk,
  // frame events
  output logic      rx_preamble,
  output logic      rx_da_valid,
  output logic      rx_is_multicast,
  output logic      rx_is_broadcast,
  output logic      rx_addr_match
);
  // ========
  // frames
  initial begin
    rx_preamble = 1'b0;
    rx_da_valid = 1'b0;
    {rx_is_multicast, rx_is_broadcast, rx_addr_match} = 3'h5;
  end
  // flags mean nothing outside the decode pulse, so show them inverted
  task automatic send_frame(input logic [2:0] flags, input int gap);
    rx_preamble <= 1'b1;
    @(posedge pclk);
    rx_preamble <= 1'b0;
    repeat (gap) @(posedge pclk);
    rx_da_valid <= 1'b1;
    {rx_is_multicast, rx_is_broadcast, rx_addr_match} <= flags;
    @(posedge pclk);
    rx_da_valid <= 1'b0;
    {rx_is_multicast, rx_is_broadcast, rx_addr_match} <= ~flags;
  endtask : send_frame
endmodule : rx_station_model
`default_nettype wire

// ---- verif/test_auto_flow_control_trigger.sv ----
// bench for the flow control trigger: apb config, pause and jam checks
// assumes shortened microsecond counts; fifo level driven by the bench
`timescale 1ns/1ps
`default_nettype none
module test_auto_flow_control_trigger;
  localparam int          US_CYC  = 2;
  localparam int          X10_CYC = 4;
  // high 4 (256 bytes), low 2 (128 bytes): low kept below high
  localparam logic [31:0] BASE    = 32'h0004_0200;
  logic        pclk, presetn, psel, penable, pwrite, full_duplex, speed_100, tx_enable;
  logic        pready, pslverr, pause_req, pause_zero, jam, zero_seen, rerr;
  logic        pre, dav, mc, bc, am, pclken;
  logic [7:0]  paddr;
  logic [15:0] rx_fifo_bytes;
  logic [31:0] pwdata, prdata, rdata;
  int          fail_count, check_count, npause, jam_cycles, d;

  auto_flow_control_trigger #(.US_CYCLES(US_CYC), .EXTRA_10M_CYCLES(X10_CYC))
    u_auto_flow_control_trigger (
    .pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .full_duplex(full_duplex), .speed_100(speed_100),
    .tx_enable(tx_enable), .rx_fifo_bytes(rx_fifo_bytes), .rx_preamble(pre),
    .rx_da_valid(dav), .rx_is_multicast(mc), .rx_is_broadcast(bc), .rx_addr_match(am),
    .pause_req(pause_req), .pause_zero(pause_zero), .jam(jam));

  rx_station_model u_rx_station_model (.pclk(pclk), .rx_preamble(pre), .rx_da_valid(dav),
    .rx_is_multicast(mc), .rx_is_broadcast(bc), .rx_addr_match(am));

  // ========
  // clock and monitors
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (pause_req === 1'b1) begin
      npause++;
      zero_seen = pause_zero;
    end
    if (jam === 1'b1) jam_cycles++;
  end

  // ========
  // tasks
  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : check

  task automatic conclude();
    if (fail_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    // no limit here: only the watchdog ends a wait
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n != 1) check(1'b0, "bus wait states");
  endtask : apb

  // reach the high level, send one frame, then drain to rearm
  task automatic reach_frame(input logic [31:0] c, input logic [2:0] flags, input int hold);
    apb(1'b1, afc_pkg::CFG_OFFSET, c);
    jam_cycles = 0;
    rx_fifo_bytes <= 16'd256;
    repeat (3) @(posedge pclk);
    u_rx_station_model.send_frame(flags, 1);
    repeat (hold) @(posedge pclk);
    rx_fifo_bytes <= 16'd0;
    repeat (4) @(posedge pclk);
  endtask : reach_frame

  function automatic int dur_cyc(input int code, input logic fast);
    int us;
    us = (code < 4) ? ((code == 3) ? 25 : 5 * (code + 1)) : 50 * (code - 3);
    return us * US_CYC + (fast ? 0 : X10_CYC);
  endfunction : dur_cyc

  // ========
  // tests
  initial begin
    {pclk, presetn, psel, penable, pwrite, full_duplex} = '0;
    {pclken, speed_100, tx_enable, paddr, pwdata, rx_fifo_bytes} = {3'b111, 56'h0};
    {npause, jam_cycles, fail_count, check_count} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, afc_pkg::CFG_OFFSET, 32'h0);
    check(rdata === 32'h0 && rerr === 1'b0, "config reset value");
    // low field kept one below high while the enables are set
    apb(1'b1, afc_pkg::CFG_OFFSET, 32'hffff_feff);
    apb(1'b0, afc_pkg::CFG_OFFSET, 32'h0);
    check(rdata === 32'h00ff_feff, "config read back");
    apb(1'b0, 8'h04, 32'h0);
    check(rerr === 1'b1 && rdata === 32'h0, "unmapped read");
    // full duplex, duration and qualifiers set but unused there
    full_duplex <= 1'b1;
    apb(1'b1, afc_pkg::CFG_OFFSET, BASE | 32'hff);
    jam_cycles = 0;
    rx_fifo_bytes <= 16'd255;
    repeat (8) @(posedge pclk);
    check(npause === 0, "pause below high level");
    // clock enable low freezes the high-level tracking and the pause registers
    pclken <= 1'b0;
    rx_fifo_bytes <= 16'd256;
    repeat (8) @(posedge pclk);
    check(npause === 0, "pause while clock enable low");
    pclken <= 1'b1;
    repeat (20) @(posedge pclk);
    check(npause === 1 && zero_seen === 1'b0, "one timed pause");
    apb(1'b0, afc_pkg::STATUS_OFFSET, 32'h0);
    check(rdata === 32'h3 && rerr === 1'b0, "status after pause");
    rx_fifo_bytes <= 16'd128;
    repeat (8) @(posedge pclk);
    check(npause === 1, "pause at low level");
    rx_fifo_bytes <= 16'd127;
    repeat (8) @(posedge pclk);
    check(npause === 2 && zero_seen === 1'b1, "zero pause");
    rx_fifo_bytes <= 16'd0;
    repeat (8) @(posedge pclk);
    check(npause === 2 && jam_cycles === 0, "repeat zero or jam");
    reach_frame(BASE | 32'he, 3'h7, 20);
    check(npause === 2 && jam_cycles === 0, "full duplex without any");
    tx_enable <= 1'b0;
    reach_frame(BASE | 32'h1, 3'h0, 20);
    check(npause === 2, "pause while tx off");
    full_duplex <= 1'b0;
    reach_frame(BASE | 32'h1, 3'h0, 20);
    check(jam_cycles === 0, "jam while tx off");
    tx_enable <= 1'b1;
    // half duplex duration table, window timed from the level reach
    for (int code = 0; code < 17; code++) begin
      speed_100 <= (code < 16);
      d = dur_cyc(code % 16, code < 16);
      reach_frame(BASE | 32'(((code % 16) << 4) | 15), 3'h0, d + 4);
      // window opens one cycle after the reach, preamble two later
      check(jam_cycles === d - 2, "jam span");
    end
    for (int b = 1; b < 4; b++) begin
      reach_frame(BASE | 32'(1 << b), ~3'(1 << (b - 1)), 14);
      check(jam_cycles === 0, "unqualified frame jammed");
      reach_frame(BASE | 32'(1 << b), 3'(1 << (b - 1)), 14);
      check(jam_cycles > 0, "qualified frame not jammed");
    end
    check(npause === 2, "pause in half duplex");
    conclude();
  end

  initial begin
    repeat (60000) @(posedge pclk);
    fail_count++;
    $display("CHECK FAILED %0t watchdog", $time);
    conclude();
  end
endmodule : test_auto_flow_control_trigger
`default_nettype wire
